// [hw/wpc_pkg.sv]
// Shared types of the write-protect control block
package wpc_pkg;
   typedef logic [1:0] wpc_resp_type;
   typedef logic [1:0] wpc_mode_type;
   typedef logic [2:0] wpc_code_type;
endpackage : wpc_pkg

// [hw/wpc_regs.svh]
// Register map, field positions, reset values and identity defaults
`ifndef WPC_REGS_SVH
`define WPC_REGS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define WPC_IDX_STATUS   8'h00
`define WPC_IDX_CFG_ONE  8'h02
`define WPC_IDX_FLAG     8'h0A
`define WPC_IDX_IDENT    8'h30
`define WPC_IDX_LATCHCMD 8'h3C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define WPC_SR_PINEN     7
`define WPC_SR_RSV_HI    6
`define WPC_SR_BOTTOM    5
`define WPC_SR_BP_HI     4
`define WPC_SR_BP_LO     2
`define WPC_SR_LATCH     1
`define WPC_SR_RSV_LO    0
`define WPC_CFG_DRV_HI   7
`define WPC_CFG_DRV_LO   5
`define WPC_CFG_LOCK     2
`define WPC_CFG_MODE_HI  1
`define WPC_CFG_MODE_LO  0
`define WPC_FLAG_READY   7
`define WPC_CMD_SET      0
`define WPC_CMD_CLEAR    1

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define WPC_DRV_RESET    3'h3
`define WPC_MODE_NORMAL  2'h0
`define WPC_MODE_SRAM    2'h1
`define WPC_MODE_B2B     2'h2
`define WPC_BP_NONE      3'h0
`define WPC_BP_ALL       3'h7
`define WPC_BP_FRAC_MAX  3
`define WPC_ID_MFR       8'h5A
`define WPC_ID_IFACE     4'h2
`define WPC_ID_VOLT      4'h1
`define WPC_ID_TEMP      4'h0
`define WPC_ID_DENS      4'h1
`define WPC_ID_FREQ      8'h01
`define WPC_RESP_OKAY    2'h0
`define WPC_RESP_SLVERR  2'h2

`endif

// [hw/wpc_top.sv]
// Write-protect control: block protection, latch handling, register file
`timescale 1ns/1ps
`include "wpc_regs.svh"

module wpc_top #(
   parameter int ADDR_W = 23,                     // Array address width, 64Mb
   parameter int BUS_W  = 8                       // Register bus address width
) (
   input  wire logic                 mclk,          // System clock, 40 MHz
   input  wire logic                 rst,           // Asynchronous reset, high
   input  wire logic [BUS_W-1:0]     s_axi_awaddr,  // Write address
   input  wire logic                 s_axi_awvalid, // Write address valid
   output logic                      s_axi_awready, // Write address ready
   input  wire logic [31:0]          s_axi_wdata,   // Write data
   input  wire logic [3:0]           s_axi_wstrb,   // Write byte strobes
   input  wire logic                 s_axi_wvalid,  // Write data valid
   output logic                      s_axi_wready,  // Write data ready
   output wpc_pkg::wpc_resp_type     s_axi_bresp,   // Write response
   output logic                      s_axi_bvalid,  // Write response valid
   input  wire logic                 s_axi_bready,  // Write response ready
   input  wire logic [BUS_W-1:0]     s_axi_araddr,  // Read address
   input  wire logic                 s_axi_arvalid, // Read address valid
   output logic                      s_axi_arready, // Read address ready
   output logic [31:0]               s_axi_rdata,   // Read data
   output wpc_pkg::wpc_resp_type     s_axi_rresp,   // Read response
   output logic                      s_axi_rvalid,  // Read data valid
   input  wire logic                 s_axi_rready,  // Read data ready
   input  wire logic [2:0]           hw_block_protect_pin, // Pin block-protect code
   input  wire logic                 hw_bottom_select,     // Pin bottom select
   input  wire logic                 write_protect_n,      // Write-protect pin, low
   input  wire logic                 chip_select_n,        // Chip select pin, low
   input  wire logic                 busy_in,       // Array busy from core
   input  wire logic                 arr_req,       // Array write request pulse
   input  wire logic [ADDR_W-1:0]    arr_addr,      // Array write address
   output logic                      arr_grant,     // Array write accepted pulse
   output logic                      arr_deny,      // Array write refused pulse
   output logic                      write_enable_latch, // Latch state
   output logic [2:0]                drive_strength_select // Output drive code
);
   import wpc_pkg::*;

   // ------------------------------------------------------------------
   // Protection decode
   // ------------------------------------------------------------------
   function automatic logic in_region(input logic [ADDR_W-1:0] a,
                                      input wpc_code_type code,
                                      input logic bottom);
      logic hit;
      int   n;
      hit = 1'b1;
      n   = 7 - int'(code);
      if (code == `WPC_BP_NONE)
         hit = 1'b0;
      else if (code != `WPC_BP_ALL)
         for (int i = 0; i < 6; i++)
            if (i < n && a[ADDR_W-1-i] == bottom)
               hit = 1'b0;
      return hit;
   endfunction : in_region

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic [5:0] pin_meta;
   logic [5:0] pin_sync;
   logic       cs_n_last;
   logic [2:0] pin_bp;
   logic       pin_bottom;
   logic       wp_pin;
   logic       cs_rise;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pin_meta  <= 6'h3F;
         pin_sync  <= 6'h3F;
         cs_n_last <= 1'b1;
      end else begin
         pin_meta  <= {chip_select_n, write_protect_n, hw_bottom_select,
                       hw_block_protect_pin};
         pin_sync  <= pin_meta;
         cs_n_last <= pin_sync[5];
      end
   end

   assign pin_bp     = pin_sync[2:0];
   assign pin_bottom = pin_sync[3];
   assign wp_pin     = pin_sync[4];
   assign cs_rise    = pin_sync[5] & ~cs_n_last;

   // ------------------------------------------------------------------
   // Register bus slave
   // ------------------------------------------------------------------
   logic              aw_hold;
   logic              w_hold;
   logic [BUS_W-1:0]  aw_addr;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;
   logic              wr_do;
   logic [BUS_W-3:0]  wr_idx;
   logic              sel_sr;
   logic              sel_cfg;
   logic              sel_cmd;
   logic              wr_known;

   assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign wr_do   = aw_hold & w_hold;
   assign wr_idx  = aw_addr[BUS_W-1:2];
   assign sel_sr  = wr_do & w_strb[0] & (wr_idx == `WPC_IDX_STATUS);
   assign sel_cfg = wr_do & w_strb[0] & (wr_idx == `WPC_IDX_CFG_ONE);
   assign sel_cmd = wr_do & w_strb[0] & (wr_idx == `WPC_IDX_LATCHCMD);
   assign wr_known = (wr_idx == `WPC_IDX_STATUS) | (wr_idx == `WPC_IDX_CFG_ONE) |
                     (wr_idx == `WPC_IDX_LATCHCMD) | (wr_idx == `WPC_IDX_FLAG) |
                     (wr_idx == `WPC_IDX_IDENT);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         aw_hold      <= 1'b0;
         w_hold       <= 1'b0;
         aw_addr      <= '0;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `WPC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_do) begin
            aw_hold      <= 1'b0;
            w_hold       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // Refused protected writes still answer OKAY, silently dropped
            s_axi_bresp  <= wr_known ? `WPC_RESP_OKAY : `WPC_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Protection registers and latch
   // ------------------------------------------------------------------
   logic         sr_pinen;
   logic         sr_rsv_hi;
   logic         sr_bottom;
   wpc_code_type sr_bp;
   logic         sr_rsv_lo;
   logic         cfg_lock;
   wpc_mode_type cfg_mode;
   logic         reg_wr_seen;
   logic         reg_ok;
   logic         cmd_set;
   logic         cmd_clear;
   logic         prot_soft;
   logic         prot_hw;
   logic         prot_any;
   logic         arr_ok;

   assign reg_ok    = write_enable_latch & ~(sr_pinen & ~wp_pin);
   assign cmd_set   = sel_cmd & w_data[`WPC_CMD_SET];
   assign cmd_clear = sel_cmd & w_data[`WPC_CMD_CLEAR];
   assign prot_soft = in_region(arr_addr, sr_bp, sr_bottom);
   assign prot_hw   = in_region(arr_addr, pin_bp, pin_bottom);
   assign prot_any  = prot_soft | prot_hw;
   // Reserved mode 11 is treated like normal mode
   assign arr_ok    = ~prot_any & (write_enable_latch |
                      (cfg_mode == `WPC_MODE_SRAM));

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sr_pinen  <= 1'b0;
         sr_rsv_hi <= 1'b0;
         sr_bottom <= 1'b0;
         sr_bp     <= `WPC_BP_NONE;
         sr_rsv_lo <= 1'b0;
      end else if (sel_sr && reg_ok) begin
         sr_pinen  <= w_data[`WPC_SR_PINEN];
         sr_rsv_hi <= w_data[`WPC_SR_RSV_HI];
         sr_rsv_lo <= w_data[`WPC_SR_RSV_LO];
         if (!cfg_lock) begin
            sr_bottom <= w_data[`WPC_SR_BOTTOM];
            sr_bp     <= w_data[`WPC_SR_BP_HI:`WPC_SR_BP_LO];
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         drive_strength_select <= `WPC_DRV_RESET;
         cfg_lock              <= 1'b0;
         cfg_mode              <= `WPC_MODE_NORMAL;
      end else if (sel_cfg && reg_ok) begin
         drive_strength_select <= w_data[`WPC_CFG_DRV_HI:`WPC_CFG_DRV_LO];
         cfg_lock              <= w_data[`WPC_CFG_LOCK];
         cfg_mode              <= w_data[`WPC_CFG_MODE_HI:`WPC_CFG_MODE_LO];
      end
   end

   // A status or config register write in the frame forces a clear at the chip-select rise
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         reg_wr_seen <= 1'b0;
      else if (sel_sr || sel_cfg)
         reg_wr_seen <= 1'b1;
      else if (cs_rise)
         reg_wr_seen <= 1'b0;
   end

   // Set wins over any clear in the same cycle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         write_enable_latch <= 1'b0;
      else if (cmd_set)
         write_enable_latch <= 1'b1;
      else if (cmd_clear)
         write_enable_latch <= 1'b0;
      else if (cs_rise && (reg_wr_seen || cfg_mode != `WPC_MODE_B2B))
         write_enable_latch <= 1'b0;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         arr_grant <= 1'b0;
         arr_deny  <= 1'b0;
      end else begin
         arr_grant <= arr_req & arr_ok;
         arr_deny  <= arr_req & ~arr_ok;
      end
   end

   // ------------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------------
   logic        fsr_ready;
   logic [31:0] next_rdata;
   logic [31:0] ident;

   // Manufacturer code is arbitrary
   assign ident = {`WPC_ID_MFR, `WPC_ID_IFACE, `WPC_ID_VOLT, `WPC_ID_TEMP,
                   `WPC_ID_DENS, `WPC_ID_FREQ};

   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         fsr_ready <= 1'b1;
      else
         fsr_ready <= ~busy_in;
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      case (s_axi_araddr[BUS_W-1:2])
         `WPC_IDX_STATUS:
            next_rdata[7:0] = {sr_pinen, sr_rsv_hi, sr_bottom, sr_bp,
                               write_enable_latch, sr_rsv_lo};
         `WPC_IDX_CFG_ONE:
            next_rdata[7:0] = {drive_strength_select, 2'b00, cfg_lock, cfg_mode};
         `WPC_IDX_FLAG:
            next_rdata[`WPC_FLAG_READY] = fsr_ready;
         `WPC_IDX_IDENT:
            next_rdata = ident;
         default:
            next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `WPC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         case (s_axi_araddr[BUS_W-1:2])
            `WPC_IDX_STATUS, `WPC_IDX_CFG_ONE, `WPC_IDX_FLAG, `WPC_IDX_IDENT,
            `WPC_IDX_LATCHCMD: s_axi_rresp <= `WPC_RESP_OKAY;
            default:           s_axi_rresp <= `WPC_RESP_SLVERR;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   a_latch_guard: assert property (@(posedge mclk) disable iff (rst)
      (sel_sr && !write_enable_latch) |=> $stable(sr_bp) && $stable(sr_pinen))
      else $error("status changed with latch clear");
   a_pin_guard: assert property (@(posedge mclk) disable iff (rst)
      (sel_cfg && sr_pinen && !wp_pin) |=> $stable(cfg_mode) && $stable(cfg_lock))
      else $error("config changed while pin protect active");
   a_lock_hold: assert property (@(posedge mclk) disable iff (rst)
      (sel_sr && cfg_lock) |=> $stable(sr_bp) && $stable(sr_bottom))
      else $error("locked protect bits changed");
   a_prot_deny: assert property (@(posedge mclk) disable iff (rst)
      (arr_req && prot_any) |=> arr_deny && !arr_grant)
      else $error("protected array write granted");
   a_open_grant: assert property (@(posedge mclk) disable iff (rst)
      (arr_req && !prot_any && write_enable_latch) |=> arr_grant)
      else $error("unprotected write refused with latch set");
   a_sram_mode: assert property (@(posedge mclk) disable iff (rst)
      (arr_req && !prot_any && cfg_mode == `WPC_MODE_SRAM) |=> arr_grant)
      else $error("latch-free mode refused write");
   a_keep_latch: assert property (@(posedge mclk) disable iff (rst)
      (cs_rise && cfg_mode == `WPC_MODE_B2B && !reg_wr_seen && !cmd_clear &&
       write_enable_latch) |=> write_enable_latch)
      else $error("persistent latch dropped");
   a_reg_clear: assert property (@(posedge mclk) disable iff (rst)
      (cs_rise && reg_wr_seen && !cmd_set) |=> !write_enable_latch)
      else $error("latch kept after register write");
   a_ready_flag: assert property (@(posedge mclk) disable iff (rst)
      ##1 (fsr_ready == !$past(busy_in)))
      else $error("ready flag wrong");
   a_hw_none: assert property (@(posedge mclk) disable iff (rst)
      (pin_bp == `WPC_BP_NONE) |-> !prot_hw)
      else $error("pin protection with pins low");

endmodule : wpc_top

// [tb/wpc_host_model.sv]
// Host-side model: chip select framing and array write requests
`timescale 1ns/1ps
module wpc_host_model (
   input  wire logic        mclk,          // System clock
   input  wire logic        arr_grant,     // Write accepted pulse
   input  wire logic        arr_deny,      // Write refused pulse
   output logic             chip_select_n, // Chip select, low
   output logic             arr_req,       // Array write request
   output logic [22:0]      arr_addr       // Array write address
);
   initial begin
      chip_select_n = 1'b0;
      arr_req       = 1'b0;
      arr_addr      = 23'h000000;
   end
   // One-cycle request; the answer is sampled at the following edge
   task automatic arr_write(input logic [22:0] a, output logic g, output logic d);
      arr_req  <= 1'b1;
      arr_addr <= a;
      @(posedge mclk);
      arr_req  <= 1'b0;
      arr_addr <= ~a;
      @(posedge mclk);
      g = arr_grant;
      d = arr_deny;
   endtask : arr_write
   // Chip select high long enough to pass the pin synchroniser
   task automatic frame_end();
      chip_select_n <= 1'b1;
      repeat (5) @(posedge mclk);
      chip_select_n <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask : frame_end
endmodule : wpc_host_model

// [tb/wpc_top_bench.sv]
// Self-checking bench of the write-protect control block
`timescale 1ns/1ps
`include "wpc_regs.svh"
module wpc_top_bench;
   import wpc_pkg::*;
   logic mclk, rst, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, bsel, wp_n, busy;
   logic cs_n, req, grant, deny, latch;
   logic [7:0]   awa, ara;
   logic [31:0]  wd, rd;
   logic [3:0]   ws;
   logic [2:0]   pins, drv;
   logic [22:0]  addr;
   wpc_resp_type bresp, rresp;
   int fails, cmp_count;
   localparam logic [7:0] STAT = 8'(`WPC_IDX_STATUS * 4);
   localparam logic [7:0] CF   = 8'(`WPC_IDX_CFG_ONE * 4);
   localparam logic [7:0] FL   = 8'(`WPC_IDX_FLAG * 4);
   localparam logic [7:0] IDN  = 8'(`WPC_IDX_IDENT * 4);
   localparam logic [7:0] LC   = 8'(`WPC_IDX_LATCHCMD * 4);
   wpc_top dut (.mclk(mclk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
      .hw_block_protect_pin(pins), .hw_bottom_select(bsel), .write_protect_n(wp_n),
      .chip_select_n(cs_n), .busy_in(busy), .arr_req(req), .arr_addr(addr),
      .arr_grant(grant), .arr_deny(deny), .write_enable_latch(latch),
      .drive_strength_select(drv));
   wpc_host_model host (.mclk(mclk), .arr_grant(grant), .arr_deny(deny),
      .chip_select_n(cs_n), .arr_req(req), .arr_addr(addr));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input wpc_resp_type e);
      logic aw_ok, w_ok;
      aw_ok = 0;
      w_ok = 0;
      awa <= a;
      wd  <= d;
      awv <= 1'b1;
      wv  <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge mclk);
         if (!aw_ok && awr === 1'b1) begin
            aw_ok = 1;
            awv <= 1'b0;
            awa <= ~a;
         end
         if (!w_ok && wr === 1'b1) begin
            w_ok = 1;
            wv <= 1'b0;
            wd <= ~d;
         end
      end
      // Ready of the answer channels stays high, so back-to-back calls never toggle it
      do @(posedge mclk); while (bv !== 1'b1);
      chk(bresp, e);
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input wpc_resp_type er);
      ara <= a;
      arv <= 1'b1;
      do @(posedge mclk); while (arr !== 1'b1);
      arv <= 1'b0;
      ara <= ~a;
      do @(posedge mclk); while (rv !== 1'b1);
      chk(rd, e);
      chk(rresp, er);
   endtask : rd_reg
   task automatic try_arr(input logic [22:0] a, input logic ok);
      logic g, d;
      host.arr_write(a, g, d);
      chk(g, ok);
      chk(d, !ok);
   endtask : try_arr
   // Protected region: none at 0, size 2^(16+c) for 1 to 6, whole array at 7, from top or bottom
   function automatic logic guarded(input logic b, input int c, input int a);
      int sz;
      sz = (c == 0) ? 0 : (c == 7) ? 32'h800000 : (1 << (16 + c));
      return b ? (a < sz) : (a >= 32'h800000 - sz);
   endfunction : guarded
   task automatic t_reset();
      rd_reg(CF, 32'h60, `WPC_RESP_OKAY);
      rd_reg(STAT, 32'h00, `WPC_RESP_OKAY);
      rd_reg(FL, 32'h80, `WPC_RESP_OKAY);
      wr_reg(IDN, 32'h0, `WPC_RESP_OKAY);
      rd_reg(IDN, {`WPC_ID_MFR, 24'h210101}, `WPC_RESP_OKAY);
      rd_reg(8'h04, 32'h0, `WPC_RESP_SLVERR);
      wr_reg(8'h04, 32'h1, `WPC_RESP_SLVERR);
      wr_reg(STAT, 32'h04, `WPC_RESP_OKAY);
      rd_reg(STAT, 32'h00, `WPC_RESP_OKAY);
      try_arr(23'h000000, 1'b0);
      busy <= 1'b1;
      // The flag follows busy one register stage later
      @(posedge mclk);
      rd_reg(FL, 32'h00, `WPC_RESP_OKAY);
      busy <= 1'b0;
      $display("test reset values done");
   endtask : t_reset
   task automatic t_decode();
      int a[4];
      int sz;
      wr_reg(LC, 32'h1, `WPC_RESP_OKAY);
      for (int b = 0; b < 2; b++) begin
         for (int c = 0; c < 8; c++) begin
            wr_reg(STAT, {26'h0, b[0], c[2:0], 2'b00}, `WPC_RESP_OKAY);
            sz = (c == 7) ? 32'h800000 : (c == 0) ? 0 : (1 << (16 + c));
            a = '{(sz - 1) & 32'h7FFFFF, sz & 32'h7FFFFF,
                  (32'h7FFFFF - sz) & 32'h7FFFFF, (32'h800000 - sz) & 32'h7FFFFF};
            for (int i = 0; i < 4; i++)
               try_arr(a[i][22:0], !guarded(b[0], c, a[i]));
         end
      end
      wr_reg(STAT, 32'h04, `WPC_RESP_OKAY);
      pins <= 3'h3;
      bsel <= 1'b1;
      repeat (3) @(posedge mclk);
      try_arr(23'h7E0000, 1'b0);
      try_arr(23'h07FFFF, 1'b0);
      try_arr(23'h080000, 1'b1);
      pins <= 3'h0;
      repeat (3) @(posedge mclk);
      try_arr(23'h07FFFF, 1'b1);
      $display("test decode done");
   endtask : t_decode
   task automatic t_regs();
      wr_reg(STAT, 32'h0C, `WPC_RESP_OKAY);
      wr_reg(CF, 32'h7C, `WPC_RESP_OKAY);
      rd_reg(CF, 32'h64, `WPC_RESP_OKAY);
      wr_reg(STAT, 32'h3C, `WPC_RESP_OKAY);
      rd_reg(STAT, 32'h0E, `WPC_RESP_OKAY);
      wr_reg(CF, 32'h60, `WPC_RESP_OKAY);
      wr_reg(STAT, 32'h3C, `WPC_RESP_OKAY);
      rd_reg(STAT, 32'h3E, `WPC_RESP_OKAY);
      wr_reg(STAT, 32'h80, `WPC_RESP_OKAY);
      wp_n <= 1'b0;
      repeat (3) @(posedge mclk);
      wr_reg(STAT, 32'h84, `WPC_RESP_OKAY);
      rd_reg(STAT, 32'h82, `WPC_RESP_OKAY);
      try_arr(23'h000000, 1'b1);
      wp_n <= 1'b1;
      repeat (3) @(posedge mclk);
      wr_reg(STAT, 32'h00, `WPC_RESP_OKAY);
      rd_reg(STAT, 32'h02, `WPC_RESP_OKAY);
      $display("test registers done");
   endtask : t_regs
   task automatic t_latch();
      host.frame_end();
      chk(latch, 1'b0);
      wr_reg(LC, 32'h1, `WPC_RESP_OKAY);
      wr_reg(CF, 32'h62, `WPC_RESP_OKAY);
      host.frame_end();
      chk(latch, 1'b0);
      wr_reg(LC, 32'h1, `WPC_RESP_OKAY);
      try_arr(23'h000000, 1'b1);
      host.frame_end();
      chk(latch, 1'b1);
      try_arr(23'h000010, 1'b1);
      wr_reg(LC, 32'h2, `WPC_RESP_OKAY);
      chk(latch, 1'b0);
      try_arr(23'h000000, 1'b0);
      wr_reg(CF, 32'h61, `WPC_RESP_OKAY);
      rd_reg(CF, 32'h62, `WPC_RESP_OKAY);
      wr_reg(LC, 32'h1, `WPC_RESP_OKAY);
      wr_reg(CF, 32'h61, `WPC_RESP_OKAY);
      host.frame_end();
      chk(drv, 3'h3);
      try_arr(23'h000000, 1'b1);
      $display("test latch done");
   endtask : t_latch
   initial begin
      fails = 0; cmp_count = 0;
      rst = 1'b1;
      awv = 0;
      wv = 0;
      br = 1'b1;
      arv = 0;
      rr = 1'b1;
      awa = 8'h00; ara = 8'h00; wd = 32'h0; ws = 4'hF;
      pins = 3'h0; bsel = 0; wp_n = 1'b1; busy = 0;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      t_reset();
      t_decode();
      t_regs();
      t_latch();
      complete_run();
   end
   initial begin
      #(25.0 * 20000);
      fails++;
      complete_run();
   end
endmodule : wpc_top_bench
